// [rtl/fcp_top.sv]
/*
 * Floppy command parameter block: AXI4-Lite register file, relative seek
 * stepper, sector sequencer with deleted-mark skipping, drive polling,
 * write gate timing and the four-byte result store.
 * Assumes the drive-side inputs are asynchronous pins and the bus master
 * keeps one write and one read outstanding at most.
 */
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
// Behaviour
// RQ1: the low four perpendicular mode bits change only while perp_unlock is 1.
// RQ2: head_position_now gives the head cylinder and is reported when sense interrupt completes.
// RQ3: drive polling stops while autoscan_off is set and runs while it is clear.
// RQ4: precomp_first_track takes any value 00 to FF and marks where precompensation starts.
// RQ5: begin_slot is the sector accessed, and the first one of a multi-sector transfer.
// RQ6: cylinder_step_delta is an offset from the present cylinder in a relative seek.
// RQ7: sectors_per_track counts sectors for format, and for verify when verify_by_count is set.
// RQ8: with bypass_deleted_mark set, read data skips every sector with a deleted mark.
// RQ9: with bypass_deleted_mark set, read deleted accesses only sectors with a deleted mark.
// RQ10: with bypass_deleted_mark clear, every sector is accessed with no skipping.
// RQ11: step pulses are spaced by step_rate_interval, 0.5 to 8 ms in 0.5 ms steps.
// RQ12: four result registers hold status after each command and are readable by the host.
// RQ13: write_gate_shift changes write_strobe timing to give pre-erase time.
`timescale 1ns/100ps
`include "fcp_defines.svh"
module fcp_top #(
	parameter int STEP_UNIT_CYC = `FCP_STEP_UNIT_NS / `FCP_CLK_NS,
	parameter int POLL_CYC      = `FCP_POLL_NS / `FCP_CLK_NS
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sector_pulse_in,
	input  wire logic        deleted_mark_in,
	output logic             step_out,
	output logic             step_dir_out,
	output logic             write_strobe,
	output logic             precomp_active,
	output logic             sector_access,
	output logic [7:0]       sector_number,
	output logic             poll_strobe,
	output logic [3:0]       perp_mode,
	output logic             irq
);
	import fcp_pkg::*;

	localparam int WG_CYC = `FCP_WG_NS / `FCP_CLK_NS;

	// register index 0..14 from a byte address, 15 when unmapped
	function automatic logic [3:0] fcp_index(input logic [7:0] addr);
		logic [3:0] idx;
		idx = 4'hF;
		if (addr[1:0] == 2'h0 && addr <= `FCP_A_XFER) begin
			idx = addr[5:2];
		end
		return idx;
	endfunction

	function automatic logic [31:0] fcp_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// bus side
	logic        aw_have_reg, w_have_reg, bvalid_reg, rpend_reg, rvalid_reg;
	logic [7:0]  awaddr_reg, araddr_reg;
	logic [31:0] wdata_reg, rdata_reg;
	logic [3:0]  wstrb_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	// software state
	logic [`FCP_CTRL_W-1:0] ctrl_reg;
	logic [3:0]  perp_reg, step_rate_interval;
	logic [7:0]  precomp_first_track, begin_slot, sectors_per_track;
	logic [8:0]  seek_reg;
	logic [`FCP_IRQ_W-1:0] status_reg, mask_reg;
	// sequencer
	fcp_state_type state_reg;
	fcp_cmd_type   cmd_reg;
	logic [7:0]  head_position_now, steps_left_reg, cur_sector_reg;
	logic [7:0]  done_cnt_reg, skip_cnt_reg;
	logic [19:0] step_cnt_reg;
	logic [1:0]  res_idx_reg;
	logic [7:0]  wg_cnt_reg;
	logic [31:0] poll_cnt_reg;
	logic        step_reg, access_reg;
	logic [7:0]  secnum_reg;
	// pins
	logic [1:0]  sync1_reg, sync2_reg;
	logic        sec_prev_reg;

	wire [3:0]  widx          = fcp_index(awaddr_reg);
	wire [3:0]  ridx          = fcp_index(s_axi_araddr);
	wire        do_write      = aw_have_reg && w_have_reg && !bvalid_reg;
	wire        ar_fire       = s_axi_arvalid && s_axi_arready;
	wire        autoscan_off  = ctrl_reg[`FCP_CTRL_POLL_OFF];
	wire        perp_unlock   = ctrl_reg[`FCP_CTRL_UNLOCK];
	wire        bypass_deleted_mark = ctrl_reg[`FCP_CTRL_BYPASS];
	wire        verify_by_count     = ctrl_reg[`FCP_CTRL_BYCOUNT];
	wire        write_gate_shift    = ctrl_reg[`FCP_CTRL_WGSHIFT];
	wire [7:0]  cylinder_step_delta = seek_reg[7:0];
	wire        idle          = (state_reg == FCP_ST_IDLE);
	wire        cmd_start     = do_write && widx == `FCP_A_CMD >> 2 && idle && wstrb_reg[0];
	wire [2:0]  cmd_code      = wdata_reg[2:0];
	wire        sector_evt    = sync2_reg[0] && !sec_prev_reg;
	wire        deleted_now   = sync2_reg[1];
	wire        writing       = cmd_reg == FCP_CMD_WRITE || cmd_reg == FCP_CMD_FORMAT;
	wire        in_xfer       = (state_reg == FCP_ST_XFER);
	wire [19:0] step_lim      = 20'(({16'h0000, step_rate_interval} + 20'h00001) * STEP_UNIT_CYC);
	wire        step_due      = step_cnt_reg == step_lim - 20'h00001;
	wire        counted       = cmd_reg == FCP_CMD_FORMAT
	                            || (cmd_reg == FCP_CMD_VERIFY && verify_by_count); // [RQ7]
	wire [7:0]  target        = counted ? sectors_per_track : 8'h01; // [RQ7]
	wire        sec_ok        = cmd_reg == FCP_CMD_READ ? !(bypass_deleted_mark && deleted_now) // [RQ8] [RQ10]
	                          : cmd_reg == FCP_CMD_READ_DEL ? (!bypass_deleted_mark || deleted_now) // [RQ9]
	                          : 1'b1;
	wire        take_sec      = in_xfer && sector_evt && sec_ok;
	wire        skip_sec      = in_xfer && sector_evt && !sec_ok;
	wire        last_sec      = take_sec && done_cnt_reg + 8'h01 >= target;
	wire        poll_tick     = !autoscan_off && poll_cnt_reg == 32'(POLL_CYC - 1);
	wire        mem_we        = (state_reg == FCP_ST_DONE);
	wire [7:0]  mem_wdata     = res_idx_reg == 2'h0 ? {5'h00, cmd_reg}
	                          : res_idx_reg == 2'h1 ? skip_cnt_reg
	                          : res_idx_reg == 2'h2 ? cur_sector_reg
	                          : head_position_now; // [RQ2]
	wire [7:0]  mem_rdata;
	wire [`FCP_IRQ_W-1:0] irq_set = {skip_sec, poll_tick, mem_we && res_idx_reg == 2'h3};
	wire [`FCP_IRQ_W-1:0] irq_clr = (do_write && widx == `FCP_A_IRQ_STAT >> 2 && wstrb_reg[0])
	                                ? wdata_reg[`FCP_IRQ_W-1:0] : '0;
	wire [31:0] wv_ctrl   = fcp_merge({27'h0, ctrl_reg}, wdata_reg, wstrb_reg);
	wire [31:0] wv_sector = fcp_merge({16'h0, sectors_per_track, begin_slot}, wdata_reg, wstrb_reg);
	wire [31:0] wv_seek   = fcp_merge({23'h0, seek_reg}, wdata_reg, wstrb_reg);
	logic [31:0] rd_mux;

	assign s_axi_awready = !aw_have_reg;
	assign s_axi_wready  = !w_have_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rpend_reg && !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;
	assign step_out      = step_reg;
	assign step_dir_out  = seek_reg[`FCP_SEEK_DIR];
	assign sector_access = access_reg;
	assign sector_number = secnum_reg;
	assign perp_mode     = perp_reg;
	assign poll_strobe   = poll_tick; // [RQ3]
	assign irq           = |(status_reg & mask_reg);
	assign precomp_active = in_xfer && writing && head_position_now >= precomp_first_track; // [RQ4]
	// shifted gate opens for the whole transfer state so the erase head is loaded ahead of data
	assign write_strobe  = in_xfer && writing && (write_gate_shift || wg_cnt_reg != 8'h00); // [RQ13]

	// the cmd write itself is not lost when ignored: it still gets OKAY
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (ridx == `FCP_A_CTRL >> 2) begin
			rd_mux = {27'h0, ctrl_reg};
		end else if (ridx == `FCP_A_PERP >> 2) begin
			rd_mux = {28'h0, perp_reg};
		end else if (ridx == `FCP_A_PRECOMP >> 2) begin
			rd_mux = {24'h0, precomp_first_track};
		end else if (ridx == `FCP_A_SECTOR >> 2) begin
			rd_mux = {16'h0, sectors_per_track, begin_slot};
		end else if (ridx == `FCP_A_SEEK >> 2) begin
			rd_mux = {23'h0, seek_reg};
		end else if (ridx == `FCP_A_STEP >> 2) begin
			rd_mux = {28'h0, step_rate_interval};
		end else if (ridx == `FCP_A_CMD >> 2) begin
			rd_mux = {25'h0, state_reg, cmd_reg};
		end else if (ridx == `FCP_A_POS >> 2) begin
			rd_mux = {24'h0, head_position_now}; // [RQ2]
		end else if (ridx == `FCP_A_IRQ_STAT >> 2) begin
			rd_mux = {29'h0, status_reg};
		end else if (ridx == `FCP_A_IRQ_MASK >> 2) begin
			rd_mux = {29'h0, mask_reg};
		end else if (ridx == `FCP_A_XFER >> 2) begin
			rd_mux = {8'h0, skip_cnt_reg, done_cnt_reg, cur_sector_reg};
		end
	end

	fcp_result_mem u_result (
		.core_clk (core_clk),
		.rst      (rst),
		.we       (mem_we),
		.waddr    (res_idx_reg),
		.wdata    (mem_wdata),
		.raddr    (s_axi_araddr[3:2]),
		.rdata    (mem_rdata)
	); // [RQ12]

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
				end else begin
					sync1_reg[g] <= g == 0 ? sector_pulse_in : deleted_mark_in;
					sync2_reg[g] <= sync1_reg[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			bresp_reg   <= `FCP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_have_reg) begin
				aw_have_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_reg <= 1'b0;
			end
			if (s_axi_wvalid && !w_have_reg) begin
				w_have_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_reg <= 1'b0;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= (widx == 4'hF) ? `FCP_RESP_SLVERR : `FCP_RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rpend_reg  <= 1'b0;
			rvalid_reg <= 1'b0;
			araddr_reg <= 8'h00;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= `FCP_RESP_OKAY;
		end else if (ar_fire) begin
			rpend_reg  <= 1'b1;
			araddr_reg <= s_axi_araddr;
			rdata_reg  <= rd_mux;
			rresp_reg  <= (ridx == 4'hF) ? `FCP_RESP_SLVERR : `FCP_RESP_OKAY;
		end else if (rpend_reg) begin
			// result words come from the store, whose output lags the address by one edge
			rpend_reg  <= 1'b0;
			rvalid_reg <= 1'b1;
			if (araddr_reg >= `FCP_A_RES_A && araddr_reg <= `FCP_A_RES_D) begin
				rdata_reg <= {24'h0, mem_rdata}; // [RQ12]
			end
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg            <= `FCP_CTRL_RST;
			perp_reg            <= `FCP_PERP_RST;
			precomp_first_track <= `FCP_PRECOMP_RST;
			begin_slot          <= `FCP_BEGIN_RST;
			sectors_per_track   <= `FCP_COUNT_RST;
			seek_reg            <= `FCP_SEEK_RST;
			step_rate_interval  <= `FCP_STEP_RST;
			mask_reg            <= `FCP_MASK_RST;
		end else if (do_write) begin
			if (widx == `FCP_A_CTRL >> 2) begin
				ctrl_reg <= wv_ctrl[`FCP_CTRL_W-1:0];
			end else if (widx == `FCP_A_PERP >> 2 && perp_unlock && wstrb_reg[0]) begin
				perp_reg <= wdata_reg[3:0]; // [RQ1]
			end else if (widx == `FCP_A_PRECOMP >> 2 && wstrb_reg[0]) begin
				precomp_first_track <= wdata_reg[7:0]; // [RQ4]
			end else if (widx == `FCP_A_SECTOR >> 2) begin
				begin_slot        <= wv_sector[`FCP_SEC_BEGIN_LSB +: 8];
				sectors_per_track <= wv_sector[`FCP_SEC_COUNT_LSB +: 8];
			end else if (widx == `FCP_A_SEEK >> 2) begin
				seek_reg <= wv_seek[8:0];
			end else if (widx == `FCP_A_STEP >> 2 && wstrb_reg[0]) begin
				step_rate_interval <= wdata_reg[3:0]; // [RQ11]
			end else if (widx == `FCP_A_IRQ_MASK >> 2 && wstrb_reg[0]) begin
				mask_reg <= wdata_reg[`FCP_IRQ_W-1:0];
			end
		end
	end

	// set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status_reg   <= '0;
			poll_cnt_reg <= 32'h0000_0000;
			sec_prev_reg <= 1'b0;
			access_reg   <= 1'b0;
			secnum_reg   <= 8'h00;
			wg_cnt_reg   <= 8'h00;
		end else begin
			status_reg   <= (status_reg & ~irq_clr) | irq_set;
			poll_cnt_reg <= (autoscan_off || poll_tick) ? 32'h0 : poll_cnt_reg + 32'h1; // [RQ3]
			sec_prev_reg <= sync2_reg[0];
			access_reg   <= take_sec;
			if (take_sec) begin
				secnum_reg <= cur_sector_reg; // [RQ5]
			end
			if (take_sec && writing) begin
				wg_cnt_reg <= 8'(WG_CYC);
			end else if (wg_cnt_reg != 8'h00) begin
				wg_cnt_reg <= wg_cnt_reg - 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg         <= FCP_ST_IDLE;
			cmd_reg           <= FCP_CMD_SEEK_REL;
			head_position_now <= 8'h00;
			steps_left_reg    <= 8'h00;
			step_cnt_reg      <= 20'h00000;
			step_reg          <= 1'b0;
			cur_sector_reg    <= 8'h00;
			done_cnt_reg      <= 8'h00;
			skip_cnt_reg      <= 8'h00;
			res_idx_reg       <= 2'h0;
		end else begin
			step_reg <= 1'b0;
			case (state_reg)
				FCP_ST_IDLE: begin
					res_idx_reg <= 2'h0;
					if (cmd_start) begin
						cmd_reg        <= fcp_cmd_type'(cmd_code);
						steps_left_reg <= cylinder_step_delta; // [RQ6]
						step_cnt_reg   <= 20'h00000;
						cur_sector_reg <= begin_slot; // [RQ5]
						done_cnt_reg   <= 8'h00;
						skip_cnt_reg   <= 8'h00;
						if (cmd_code == FCP_CMD_SEEK_REL) begin
							state_reg <= FCP_ST_SEEK;
						end else if (cmd_code == FCP_CMD_SENSE) begin
							state_reg <= FCP_ST_DONE; // [RQ2]
						end else begin
							state_reg <= FCP_ST_XFER;
						end
					end
				end
				FCP_ST_SEEK: begin
					if (steps_left_reg == 8'h00) begin
						state_reg <= FCP_ST_DONE;
					end else if (step_due) begin
						step_reg       <= 1'b1; // [RQ11]
						step_cnt_reg   <= 20'h00000;
						steps_left_reg <= steps_left_reg - 8'h01;
						head_position_now <= seek_reg[`FCP_SEEK_DIR]
							? head_position_now + 8'h01 : head_position_now - 8'h01; // [RQ6]
					end else begin
						step_cnt_reg <= step_cnt_reg + 20'h00001;
					end
				end
				FCP_ST_XFER: begin
					if (take_sec) begin
						cur_sector_reg <= cur_sector_reg + 8'h01;
						done_cnt_reg   <= done_cnt_reg + 8'h01;
						if (last_sec) begin
							state_reg <= FCP_ST_DONE; // [RQ7]
						end
					end else if (skip_sec) begin
						skip_cnt_reg <= skip_cnt_reg + 8'h01; // [RQ8] [RQ9]
					end
				end
				FCP_ST_DONE: begin
					res_idx_reg <= res_idx_reg + 2'h1; // [RQ12]
					if (res_idx_reg == 2'h3) begin
						state_reg <= FCP_ST_IDLE;
					end
				end
				default: begin
					state_reg <= FCP_ST_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	chk_perp_locked_hold: assert property ( // [RQ1]
		do_write && widx == 4'h1 && !perp_unlock |=> perp_reg == $past(perp_reg))
		else $error("perpendicular bits changed while locked");
	chk_sense_position: assert property ( // [RQ2]
		mem_we && res_idx_reg == 2'h3 |-> mem_wdata == head_position_now)
		else $error("result d does not carry the head cylinder");
	chk_poll_quiet: assert property ( // [RQ3]
		$past(autoscan_off) |-> poll_cnt_reg == 32'h0000_0000 && !poll_strobe)
		else $error("poll strobe while polling disabled");
	chk_precomp_start: assert property ( // [RQ4]
		precomp_active |-> head_position_now >= precomp_first_track && writing)
		else $error("precompensation active below start track");
	chk_first_sector: assert property ( // [RQ5]
		sector_access && $past(done_cnt_reg) == 8'h00 |-> sector_number == begin_slot)
		else $error("first accessed sector differs from begin slot");
	chk_seek_offset: assert property ( // [RQ6]
		step_out && step_dir_out |-> head_position_now == $past(head_position_now) + 8'h01)
		else $error("outward step did not advance the cylinder");
	chk_count_end: assert property ( // [RQ7]
		in_xfer && take_sec && counted && done_cnt_reg + 8'h01 == sectors_per_track
		|=> state_reg == FCP_ST_DONE)
		else $error("counted transfer did not end at sector count");
	chk_skip_deleted: assert property ( // [RQ8]
		sector_access && cmd_reg == FCP_CMD_READ && bypass_deleted_mark |-> !$past(deleted_now))
		else $error("deleted sector accessed during read with bypass");
	chk_deleted_only: assert property ( // [RQ9]
		sector_access && cmd_reg == FCP_CMD_READ_DEL && bypass_deleted_mark |-> $past(deleted_now))
		else $error("plain sector accessed during read deleted with bypass");
	chk_no_bypass: assert property ( // [RQ10]
		in_xfer && sector_evt && !bypass_deleted_mark |=> sector_access)
		else $error("sector skipped with bypass clear");
	chk_step_spacing: assert property ( // [RQ11]
		step_out |-> $past(step_cnt_reg) == step_lim - 20'h00001)
		else $error("step pulse off its interval");
	chk_result_write: assert property ( // [RQ12]
		state_reg == FCP_ST_DONE && res_idx_reg == 2'h0 |-> mem_we [*4] ##1 idle)
		else $error("result words not stored in four cycles");
	chk_write_gate: assert property ( // [RQ13]
		in_xfer && writing && write_gate_shift |-> write_strobe)
		else $error("shifted write gate not open");
endmodule

// [rtl/fcp_defines.svh]
/*
 * Offsets, field positions, reset values and timing figures of the floppy
 * command parameter block.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef FCP_DEFINES_SVH
`define FCP_DEFINES_SVH

// register byte offsets (AXI4-Lite, one aligned word each)
`define FCP_A_CTRL      8'h00
`define FCP_A_PERP      8'h04
`define FCP_A_PRECOMP   8'h08
`define FCP_A_SECTOR    8'h0C
`define FCP_A_SEEK      8'h10
`define FCP_A_STEP      8'h14
`define FCP_A_CMD       8'h18
`define FCP_A_POS       8'h1C
`define FCP_A_RES_A     8'h20
`define FCP_A_RES_B     8'h24
`define FCP_A_RES_C     8'h28
`define FCP_A_RES_D     8'h2C
`define FCP_A_IRQ_STAT  8'h30
`define FCP_A_IRQ_MASK  8'h34
`define FCP_A_XFER      8'h38

// control register fields
`define FCP_CTRL_POLL_OFF  0
`define FCP_CTRL_UNLOCK    1
`define FCP_CTRL_BYPASS    2
`define FCP_CTRL_BYCOUNT   3
`define FCP_CTRL_WGSHIFT   4
`define FCP_CTRL_W         5

// sector register fields
`define FCP_SEC_BEGIN_LSB  0
`define FCP_SEC_COUNT_LSB  8
// seek register: magnitude in [7:0], direction (1 = outward, higher) in bit 8
`define FCP_SEEK_DIR       8

// interrupt status bits
`define FCP_IRQ_DONE       0
`define FCP_IRQ_POLL       1
`define FCP_IRQ_SKIP       2
`define FCP_IRQ_W          3

// reset values
`define FCP_CTRL_RST     5'h00
`define FCP_PERP_RST     4'h0
`define FCP_PRECOMP_RST  8'h00
`define FCP_BEGIN_RST    8'h01
`define FCP_COUNT_RST    8'h01
`define FCP_SEEK_RST     9'h000
`define FCP_STEP_RST     4'h0
`define FCP_MASK_RST     3'h0

// timing
`define FCP_CLK_NS        20
`define FCP_STEP_UNIT_NS  500000
`define FCP_POLL_NS       1000000
`define FCP_WG_NS         2000

// AXI responses
`define FCP_RESP_OKAY    2'h0
`define FCP_RESP_SLVERR  2'h2

`endif

// [rtl/fcp_pkg.sv]
/*
 * Types of the floppy command parameter block: commands and sequencer states.
 * Assumes fcp_defines.svh carries all numeric constants.
 */
package fcp_pkg;

	typedef enum logic [2:0] {
		FCP_CMD_SEEK_REL = 3'h0,
		FCP_CMD_READ     = 3'h1,
		FCP_CMD_READ_DEL = 3'h2,
		FCP_CMD_WRITE    = 3'h3,
		FCP_CMD_FORMAT   = 3'h4,
		FCP_CMD_VERIFY   = 3'h5,
		FCP_CMD_SENSE    = 3'h6
	} fcp_cmd_type;

	typedef enum logic [3:0] {
		FCP_ST_IDLE = 4'h1,
		FCP_ST_SEEK = 4'h2,
		FCP_ST_XFER = 4'h4,
		FCP_ST_DONE = 4'h8
	} fcp_state_type;

endpackage

// [rtl/fcp_result_mem.sv]
/*
 * Four-entry result store; read data comes out of a register one edge after
 * the read address is presented.
 * Assumes a single writer on the same clock.
 */
`timescale 1ns/100ps
module fcp_result_mem (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       we,
	input  wire logic [1:0] waddr,
	input  wire logic [7:0] wdata,
	input  wire logic [1:0] raddr,
	output logic      [7:0] rdata
);
	logic [7:0] mem_reg [0:3];

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_word
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					mem_reg[i] <= 8'h00;
				end else if (we && waddr == i[1:0]) begin
					mem_reg[i] <= wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem_reg[raddr];
		end
	end
endmodule

// [test/fcp_drive_model.sv]
/*
 * Drive model: one sector pulse every 40 cycles while spin is high.
 * Assumes sector 0 comes first after spin rises; del_map marks deleted sectors.
 */
`timescale 1ns/100ps
module fcp_drive_model (
	input  wire logic       core_clk,
	input  wire logic       spin,
	input  wire logic [7:0] del_map,
	output logic            sector_pulse_in,
	output logic            deleted_mark_in
);
	logic [5:0] ph_reg;
	logic [2:0] idx_reg;
	wire        mark = del_map[idx_reg];
	always_ff @(posedge core_clk) begin
		ph_reg  <= (!spin || ph_reg == 6'h27) ? 6'h00 : ph_reg + 6'h01;
		idx_reg <= !spin ? 3'h0 : idx_reg + {2'h0, ph_reg == 6'h27};
	end
	assign sector_pulse_in = spin && ph_reg >= 6'h0A && ph_reg < 6'h12;
	// mark valid only around the pulse; inverted elsewhere so a late sample shows up
	assign deleted_mark_in = (ph_reg >= 6'h05 && ph_reg < 6'h1A) ? mark : !mark;
endmodule

// [test/fcp_top_tb.sv]
/*
 * Scenario bench of fcp_top with a drive model on the sector pins.
 * Assumes STEP_UNIT_CYC 4 and POLL_CYC 20.
 */
`timescale 1ns/100ps
`include "fcp_defines.svh"
module fcp_top_tb;
	import fcp_pkg::*;
	logic core_clk = 0, rst = 1, spin = 0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, del_map = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hF, perp_mode;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic sector_pulse_in, deleted_mark_in, step_out, step_dir_out, write_strobe;
	logic precomp_active, sector_access, poll_strobe, irq;
	logic [7:0] sector_number;
	int fail_count = 0, compares = 0, steps = 0, gap = 0, since = 0;
	int accs = 0, polls = 0, ws = 0, n;
	fcp_top #(.STEP_UNIT_CYC(4), .POLL_CYC(20)) dut (.*);
	fcp_drive_model drv (.*);
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		since <= step_out ? 0 : since + 1;
		if (step_out === 1'b1) begin
			steps <= steps + 1;
			gap <= since + 1;
		end
		accs <= accs + (sector_access === 1'b1);
		polls <= polls + (poll_strobe === 1'b1);
		ws <= ws + (write_strobe === 1'b1);
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// address and data may be taken on different edges; drop each when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		while (!s_axi_bvalid) @(posedge core_clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge core_clk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic cmd(input logic [2:0] c);
		wr(`FCP_A_CMD, {29'h0, c});
		// write runs here always have the gate shift on and precompensation from track 3
		if (c == FCP_CMD_WRITE) begin
			chk("gate early", 1, write_strobe);
			chk("precomp on", 1, precomp_active);
		end
		if (c == FCP_CMD_FORMAT) begin
			chk("gate late", 0, write_strobe);
			chk("precomp off", 0, precomp_active);
		end
		spin <= 1'b1;
		d = 0;
		while (!d[`FCP_IRQ_DONE]) rd(`FCP_A_IRQ_STAT);
		spin <= 1'b0;
		chk("irq raised", 1, irq);
		wr(`FCP_A_IRQ_STAT, 32'h7);
		chk("irq cleared", 0, irq);
	endtask
	task automatic t_regs;
		rd(`FCP_A_SECTOR);
		chk("sector reset", 32'h0101, d);
		rd(8'h3C);
		chk("unmapped resp", `FCP_RESP_SLVERR, r);
		wr(`FCP_A_PERP, 32'h5);
		chk("perp locked", 0, perp_mode);
		wr(`FCP_A_CTRL, 32'h2);
		wr(`FCP_A_PERP, 32'h5);
		chk("perp open", 5, perp_mode);
		wr(`FCP_A_PRECOMP, 32'hFF);
		rd(`FCP_A_PRECOMP);
		chk("precomp", 32'hFF, d);
		wr(`FCP_A_IRQ_MASK, 32'h1);
		$display("register test done");
	endtask
	task automatic t_seek;
		wr(`FCP_A_STEP, 32'h1);
		wr(`FCP_A_SEEK, 32'h103);
		cmd(FCP_CMD_SEEK_REL);
		chk("steps", 3, steps);
		chk("step gap", 8, gap);
		chk("step dir", 1, step_dir_out);
		cmd(FCP_CMD_SENSE);
		rd(`FCP_A_RES_D);
		chk("head now", 3, d);
		$display("seek test done");
	endtask
	task automatic t_xfer;
		wr(`FCP_A_CTRL, 32'h6);
		wr(`FCP_A_SECTOR, 32'h0105);
		del_map <= 8'h03;
		cmd(FCP_CMD_READ);
		rd(`FCP_A_RES_B);
		chk("read skips", 2, d);
		chk("first sector", 5, sector_number);
		del_map <= 8'h04;
		cmd(FCP_CMD_READ_DEL);
		rd(`FCP_A_RES_B);
		chk("read del skips", 2, d);
		wr(`FCP_A_CTRL, 32'h2);
		wr(`FCP_A_SECTOR, 32'h0305);
		del_map <= 8'h01;
		n = accs;
		cmd(FCP_CMD_FORMAT);
		chk("format count", 3, accs - n);
		rd(`FCP_A_RES_B);
		chk("no skips", 0, d);
		chk("write strobe", 1, ws > 0);
		wr(`FCP_A_CTRL, 32'hA);
		n = accs;
		cmd(FCP_CMD_VERIFY);
		chk("verify count", 3, accs - n);
		wr(`FCP_A_CTRL, 32'h12);
		wr(`FCP_A_PRECOMP, 32'h3);
		cmd(FCP_CMD_WRITE);
		$display("transfer test done");
	endtask
	task automatic t_poll;
		n = polls;
		repeat (100) @(posedge core_clk);
		chk("poll on", 5, polls - n);
		wr(`FCP_A_CTRL, 32'h1);
		n = polls;
		repeat (100) @(posedge core_clk);
		chk("poll off", 0, polls - n);
		$display("poll test done");
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_seek();
		t_xfer();
		t_poll();
		stop_test();
	end
	initial begin
		#1000000;
		fail_count++;
		stop_test();
	end
endmodule
